/* File: chan_in_defs.svh */
`ifndef CHAN_IN_DEFS_SVH
`define CHAN_IN_DEFS_SVH

// register byte addresses
`define CFG_ADDR 8'h00
`define CTRL_ADDR 8'h04
`define TEST_DATA_ADDR 8'h08
`define TEST_STROBE_ADDR 8'h0c
`define STATUS_ADDR 8'h10

// channel_input_config fields
`define CFG_WIDTH 16
`define CFG_RESET 16'h0000
`define CFG_FIXED_GAIN 15
`define CFG_CLK_INVERT 13
`define CFG_CLK_MAIN 12
`define CFG_OFFSET_BIN 11
`define CFG_INTERP 10
`define CFG_DELAY_HI 9
`define CFG_DELAY_LO 7
`define CFG_SWAP 4
`define CFG_MODE_HI 3
`define CFG_MODE_LO 2

// channel control fields
`define CTRL_RESET 6'h00
`define CTRL_ENSEL_HI 19
`define CTRL_ENSEL_LO 17
`define CTRL_INSEL_HI 2
`define CTRL_INSEL_LO 0

// test input fields
`define TEST_RESET 19'h00000
`define TEST_EXP_HI 18
`define TEST_EXP_LO 16
`define TEST_DATA_HI 15

// status fields
`define STAT_GAIN_LO 16
`define STAT_GAIN_HI 21

`define DB_PER_STEP 6'h06
`define MANT_MSB 15

`endif

/* File: chan_in_pkg.sv */
package chan_in_pkg;

  typedef logic [16:0] bus_word_t;

  typedef enum logic [1:0] {
    num_fixed = 2'h0,
    num_f14 = 2'h1,
    num_f15 = 2'h2,
    num_f16 = 2'h3
  } num_mode_e;

  typedef enum logic [2:0] {
    in_a = 3'h0,
    in_b = 3'h1,
    in_c = 3'h2,
    in_d = 3'h3,
    in_test = 3'h4
  } in_sel_e;

  typedef enum logic [2:0] {
    en_off = 3'h0,
    en_on = 3'h1,
    en_strobe = 3'h2
  } en_sel_e;

endpackage : chan_in_pkg

/* File: capture_link_sync.sv */
`include "chan_in_defs.svh"

// captures one input bus on its own clock and hands whole words to sys_clk
module capture_link_sync (
  input wire logic link_clk,
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic invert,
  input wire chan_in_pkg::bus_word_t pin_data,
  output chan_in_pkg::bus_word_t word_out,
  output logic word_valid
);
  import chan_in_pkg::*;

  logic rst_l1_reg, rst_l2_reg;
  logic inv_l1_reg, inv_l2_reg;
  logic ack_l1_reg, ack_l2_reg;
  logic req_reg;
  bus_word_t pos_reg, neg_reg, hold_reg;
  logic req_s1_reg, req_s2_reg, ack_reg;
  bus_word_t word_reg;
  logic valid_reg;

  always_ff @(posedge link_clk) begin
    rst_l1_reg <= sys_rst;
    rst_l2_reg <= rst_l1_reg;
    inv_l1_reg <= invert;
    inv_l2_reg <= inv_l1_reg;
    ack_l1_reg <= ack_reg;
    ack_l2_reg <= ack_l1_reg;
  end

  always_ff @(posedge link_clk) begin
    pos_reg <= pin_data;
  end

  always_ff @(negedge link_clk) begin
    neg_reg <= pin_data;
  end

  // a new word is offered only once the previous one was acknowledged,
  // so hold_reg is stable while sys_clk reads it; faster links drop words
  always_ff @(posedge link_clk) begin
    if (rst_l2_reg) begin
      req_reg <= 1'b0;
      hold_reg <= '0;
    end else if (ack_l2_reg == req_reg) begin
      hold_reg <= inv_l2_reg ? neg_reg : pos_reg;
      req_reg <= ~req_reg;
    end
  end

  always_ff @(posedge sys_clk) begin
    req_s1_reg <= req_reg;
    req_s2_reg <= req_s1_reg;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ack_reg <= 1'b0;
      valid_reg <= 1'b0;
      word_reg <= '0;
    end else begin
      ack_reg <= req_s2_reg;
      valid_reg <= req_s2_reg != ack_reg;
      if (req_s2_reg != ack_reg) begin
        word_reg <= hold_reg;
      end
    end
  end

  assign word_out = word_reg;
  assign word_valid = valid_reg;

endmodule : capture_link_sync

/* File: channel_input_formatter.sv */
// Function
// - clock-invert bit 1 captures on falling input clock edge, 0 on rising.
// - source bit picks main clock; else own bus clock, bus C always main.
// - all processing and output timing runs on main clock rising edge.
// - format bit 1 means offset binary, 0 means two's complement.
// - interpolate bit 1 interpolates between enabled samples, 0 gates.
// - delay field picks sample 0 to 7 after the input enable.
// - swap bit reverses bus so bit 0 is MSB; else bit 16.
// - mode 00 takes bits 16:1 as 16-bit fixed point, bit 0 ignored.
// - modes 01/10/11 split into 14/3, 15/2, 16/1 mantissa and exponent.
// - config bit 15 puts the gain control into fixed-gain mode.
// - config register resets to all zeros.
// - exponent adds gain in 6 dB steps, 0 to 42 dB.
// - input enable is off, always on, or one pulse per test strobe.
`include "chan_in_defs.svh"

module channel_input_formatter (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bus_a_clock,
  input wire logic bus_b_clock,
  input wire logic bus_d_clock,
  input wire chan_in_pkg::bus_word_t bus_a_data,
  input wire chan_in_pkg::bus_word_t bus_b_data,
  input wire chan_in_pkg::bus_word_t bus_c_data,
  input wire chan_in_pkg::bus_word_t bus_d_data,
  output logic [15:0] out_sample,
  output logic [5:0] out_gain_db,
  output logic out_valid,
  output logic fixed_gain_mode
);
  import chan_in_pkg::*;

  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (paddr == a);
  endfunction : addr_hit

  function automatic bus_word_t reverse17(input bus_word_t w);
    bus_word_t r;
    r = '0;
    for (int i = 0; i < 17; i++) begin
      r[i] = w[16 - i];
    end
    reverse17 = r;
  endfunction : reverse17

  // ---------------- register bus ----------------
  logic [`CFG_WIDTH-1:0] cfg_reg;
  logic [5:0] ctrl_reg;
  logic [18:0] test_reg;
  logic strobe_reg;
  logic [31:0] rdata_reg;
  logic [15:0] last_sample_reg;
  logic [5:0] last_gain_reg;

  logic setup_ph, wr_acc, known;
  in_sel_e in_sel;
  en_sel_e en_sel;

  assign setup_ph = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign known = addr_hit(`CFG_ADDR) || addr_hit(`CTRL_ADDR) ||
                 addr_hit(`TEST_DATA_ADDR) || addr_hit(`TEST_STROBE_ADDR) ||
                 addr_hit(`STATUS_ADDR);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !known;
  assign prdata = rdata_reg;

  assign in_sel = in_sel_e'(ctrl_reg[`CTRL_INSEL_HI:`CTRL_INSEL_LO]);
  assign en_sel = en_sel_e'(ctrl_reg[5:3]);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cfg_reg <= `CFG_RESET;
    end else if (wr_acc && addr_hit(`CFG_ADDR)) begin
      cfg_reg <= pwdata[`CFG_WIDTH-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl_reg <= `CTRL_RESET;
    end else if (wr_acc && addr_hit(`CTRL_ADDR)) begin
      ctrl_reg <= {pwdata[`CTRL_ENSEL_HI:`CTRL_ENSEL_LO],
                   pwdata[`CTRL_INSEL_HI:`CTRL_INSEL_LO]};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      test_reg <= `TEST_RESET;
    end else if (wr_acc && addr_hit(`TEST_DATA_ADDR)) begin
      test_reg <= pwdata[`TEST_EXP_HI:0];
    end
  end

  // one-cycle test enable for every write to the strobe address
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      strobe_reg <= 1'b0;
    end else begin
      strobe_reg <= wr_acc && addr_hit(`TEST_STROBE_ADDR);
    end
  end

  // read data is latched in the setup phase so it stands through access
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdata_reg <= '0;
    end else if (setup_ph && !pwrite) begin
      rdata_reg <= '0;
      if (addr_hit(`CFG_ADDR)) begin
        rdata_reg[`CFG_WIDTH-1:0] <= cfg_reg;
      end
      if (addr_hit(`CTRL_ADDR)) begin
        rdata_reg[`CTRL_ENSEL_HI:`CTRL_ENSEL_LO] <= ctrl_reg[5:3];
        rdata_reg[`CTRL_INSEL_HI:`CTRL_INSEL_LO] <= ctrl_reg[2:0];
      end
      if (addr_hit(`TEST_DATA_ADDR)) begin
        rdata_reg[`TEST_EXP_HI:0] <= test_reg;
      end
      if (addr_hit(`STATUS_ADDR)) begin
        rdata_reg[`TEST_DATA_HI:0] <= last_sample_reg;
        rdata_reg[`STAT_GAIN_HI:`STAT_GAIN_LO] <= last_gain_reg;
      end
    end
  end

  assign fixed_gain_mode = cfg_reg[`CFG_FIXED_GAIN];

  // ---------------- capture ----------------
  logic use_main_clk;
  logic [2:0] link_clks;
  bus_word_t link_pins [3];
  bus_word_t link_words [3];
  logic [2:0] link_valid;

  assign link_clks = {bus_d_clock, bus_b_clock, bus_a_clock};
  assign link_pins[0] = bus_a_data;
  assign link_pins[1] = bus_b_data;
  assign link_pins[2] = bus_d_data;

  generate
    for (genvar g = 0; g < 3; g++) begin : g_link
      capture_link_sync u_sync (
        .link_clk(link_clks[g]),
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .invert(cfg_reg[`CFG_CLK_INVERT]),
        .pin_data(link_pins[g]),
        .word_out(link_words[g]),
        .word_valid(link_valid[g])
      );
    end
  endgenerate

  // bus C and the spare select codes have no clock of their own, so they go the main-clock way
  assign use_main_clk = cfg_reg[`CFG_CLK_MAIN] || !(in_sel inside {in_a, in_b, in_d});

  // main-clock capture: two rising-edge flops, or one falling-edge flop then one rising-edge flop, before anything reads them
  bus_word_t selected_input_bus;
  bus_word_t pr1_reg, pr2_reg, nf1_reg, nf2_reg;

  always_comb begin
    unique case (in_sel)
      in_a: selected_input_bus = bus_a_data;
      in_b: selected_input_bus = bus_b_data;
      in_d: selected_input_bus = bus_d_data;
      default: selected_input_bus = bus_c_data;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    pr1_reg <= selected_input_bus;
    pr2_reg <= pr1_reg;
  end

  always_ff @(negedge sys_clk) begin
    nf1_reg <= selected_input_bus;
  end

  always_ff @(posedge sys_clk) begin
    nf2_reg <= nf1_reg;
  end

  // pick the raw word and its arrival pulse
  bus_word_t raw_word;
  logic raw_new;
  logic is_test;

  assign is_test = (in_sel == in_test);

  always_comb begin
    raw_word = '0;
    raw_new = 1'b0;
    if (is_test) begin
      raw_new = 1'b1;
    end else if (use_main_clk) begin
      raw_word = cfg_reg[`CFG_CLK_INVERT] ? nf2_reg : pr2_reg;
      raw_new = 1'b1;
    end else if (in_sel == in_a) begin
      raw_word = link_words[0];
      raw_new = link_valid[0];
    end else if (in_sel == in_b) begin
      raw_word = link_words[1];
      raw_new = link_valid[1];
    end else if (in_sel == in_d) begin
      raw_word = link_words[2];
      raw_new = link_valid[2];
    end
  end

  // ---------------- format decode ----------------
  bus_word_t ord_word;
  logic [15:0] mant;
  logic [2:0] expo;
  num_mode_e num_mode;

  assign num_mode = num_mode_e'(cfg_reg[`CFG_MODE_HI:`CFG_MODE_LO]);
  assign ord_word = cfg_reg[`CFG_SWAP] ? reverse17(raw_word) : raw_word;

  always_comb begin
    unique case (num_mode)
      num_fixed: begin
        mant = ord_word[16:1];
        expo = 3'h0;
      end
      num_f14: begin
        mant = {ord_word[16:3], 2'h0};
        expo = ord_word[2:0];
      end
      num_f15: begin
        mant = {ord_word[16:2], 1'h0};
        expo = {1'h0, ord_word[1:0]};
      end
      num_f16: begin
        mant = ord_word[16:1];
        expo = {2'h0, ord_word[0]};
      end
    endcase
    if (cfg_reg[`CFG_OFFSET_BIN]) begin
      mant[`MANT_MSB] = ~mant[`MANT_MSB];
    end
    if (is_test) begin
      mant = test_reg[`TEST_DATA_HI:0];
      expo = test_reg[`TEST_EXP_HI:`TEST_EXP_LO];
    end
  end

  // ---------------- input enable and demux delay ----------------
  logic en_now;
  logic pend_reg;
  logic [7:0] en_hist;
  logic [6:0] hist_reg;
  logic take;
  logic [2:0] delay;

  always_comb begin
    unique case (en_sel)
      en_on: en_now = 1'b1;
      en_strobe: en_now = strobe_reg;
      default: en_now = 1'b0;
    endcase
  end

  // a strobe between two link samples is held for the next sample;
  // a strobe in the consuming cycle goes straight into that sample and the clear still happens
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pend_reg <= 1'b0;
    end else if (en_now && !raw_new) begin
      pend_reg <= 1'b1;
    end else if (raw_new) begin
      pend_reg <= 1'b0;
    end
  end

  assign delay = cfg_reg[`CFG_DELAY_HI:`CFG_DELAY_LO];
  assign en_hist = {hist_reg, en_now || pend_reg};
  assign take = raw_new && en_hist[delay];

  // enable history advances one place per arriving sample
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      hist_reg <= '0;
    end else if (raw_new) begin
      hist_reg <= en_hist[6:0];
    end
  end

  // ---------------- output ----------------
  logic [15:0] out_sample_reg;
  logic [5:0] out_gain_reg;
  logic out_valid_reg;
  logic [5:0] gain_db;

  assign gain_db = 6'(expo * `DB_PER_STEP);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      out_sample_reg <= '0;
      out_gain_reg <= '0;
      out_valid_reg <= 1'b0;
    end else begin
      out_valid_reg <= 1'b0;
      if (take) begin
        out_sample_reg <= mant;
        out_gain_reg <= gain_db;
        out_valid_reg <= 1'b1;
      end else if (raw_new && cfg_reg[`CFG_INTERP]) begin
        // zero-stuffed samples between enabled ones feed the interpolator
        out_sample_reg <= '0;
        out_valid_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      last_sample_reg <= '0;
      last_gain_reg <= '0;
    end else if (take) begin
      last_sample_reg <= mant;
      last_gain_reg <= gain_db;
    end
  end

  assign out_sample = out_sample_reg;
  assign out_gain_db = out_gain_reg;
  assign out_valid = out_valid_reg;

endmodule : channel_input_formatter

/* File: cif_asserts.sv */
module cif_asserts (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] out_sample,
  input wire logic [5:0] out_gain_db,
  input wire logic out_valid,
  input wire logic fixed_gain_mode
);
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  logic acc;
  logic hit;
  assign acc = psel && penable;
  assign hit = paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
  sequence s_cfg_wr;
    psel && !penable ##1 acc && pwrite && paddr == 8'h00;
  endsequence
  AST_PREADY: assert property (acc |-> pready)
    else $error("access not answered");
  AST_UNMAPPED: assert property (acc && !pwrite && !hit |-> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  AST_MAPPED: assert property (acc && hit |-> !pslverr)
    else $error("mapped access refused");
  AST_CFG_RD: assert property (acc && !pwrite && paddr == 8'h00 |-> prdata[31:16] == 16'h0 && prdata[15] == fixed_gain_mode)
    else $error("config readback mismatch");
  AST_FIXGAIN: assert property (s_cfg_wr |=> fixed_gain_mode == $past(pwdata[15]))
    else $error("fixed gain not updated");
  // reset itself is the antecedent here, so the default disable is switched off
  AST_RST: assert property (disable iff (1'b0) sys_rst |=> !out_valid && !fixed_gain_mode && prdata == 32'h0)
    else $error("outputs not cleared by reset");
  AST_GAIN: assert property (out_valid |-> out_gain_db <= 6'h2a && out_gain_db % 6'h06 == 6'h00)
    else $error("gain not a 6 dB step");
  AST_HOLD: assert property (!out_valid |-> $stable(out_sample) && $stable(out_gain_db))
    else $error("output moved without valid");
endmodule : cif_asserts

bind channel_input_formatter cif_asserts i_cif_asserts (.sys_clk, .sys_rst, .paddr, .psel, .penable,
  .pwrite, .pwdata, .prdata, .pready, .pslverr, .out_sample, .out_gain_db, .out_valid, .fixed_gain_mode);

/* File: adc_model.sv */
module adc_model #(parameter time PHASE = 0) (
  input wire chan_in_pkg::bus_word_t word,
  output logic clk,
  output chan_in_pkg::bus_word_t data
);
  timeunit 1ns;
  timeprecision 100ps;
  import chan_in_pkg::*;
  initial begin
    clk = 1'b0;
    data = '0;
    #PHASE;
    forever #16 clk = ~clk;
  end
  // launch well after the rising edge so either capture edge sees settled data
  always @(posedge clk) data <= #4 word;
endmodule : adc_model

/* File: tb_channel_input_formatter.sv */
module tb_channel_input_formatter;
  timeunit 1ns;
  timeprecision 100ps;
  import chan_in_pkg::*;
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, dat, cfg;
  logic pready, pslverr, out_valid, fixed_gain_mode, err, ca, cb, cd;
  logic [15:0] out_sample, vs;
  logic [5:0] out_gain_db, vg;
  bus_word_t w[4] = '{default: '0};
  bus_word_t da, db, dd;
  logic chk_on = 1'b0;
  logic [21:0] exp_fmt = '0;
  int num_errors = 0, samples_checked = 0, nv = 0, cyc = 0, vcyc, n0, sc;
  always #20 sys_clk = ~sys_clk;
  adc_model #(.PHASE(3)) i_adc_model_a (.word(w[0]), .clk(ca), .data(da));
  adc_model #(.PHASE(7)) i_adc_model_b (.word(w[1]), .clk(cb), .data(db));
  adc_model #(.PHASE(11)) i_adc_model_d (.word(w[3]), .clk(cd), .data(dd));
  channel_input_formatter i_channel_input_formatter (.sys_clk, .sys_rst, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .bus_a_clock(ca), .bus_b_clock(cb), .bus_d_clock(cd),
    .bus_a_data(da), .bus_b_data(db), .bus_c_data(w[2]), .bus_d_data(dd), .out_sample, .out_gain_db,
    .out_valid, .fixed_gain_mode);
  always @(posedge sys_clk) begin
    cyc++;
    if (out_valid === 1'b1) begin
      nv++;
      vcyc = cyc;
      vs = out_sample;
      vg = out_gain_db;
      // every output of a settled format scenario is held against the model
      if (chk_on) `CHK({out_sample, out_gain_db}, exp_fmt)
    end
  end
  function automatic logic [21:0] decode(logic [31:0] c, bus_word_t x);
    logic [15:0] m;
    logic [2:0] e;
    if (c[4]) x = {<<{x}};
    m = c[3:2] == 2'h1 ? {x[16:3], 2'h0} : c[3:2] == 2'h2 ? {x[16:2], 1'h0} : x[16:1];
    e = c[3:2] == 2'h1 ? x[2:0] : c[3:2] == 2'h2 ? {1'h0, x[1:0]} : c[3:2] == 2'h3 ? {2'h0, x[0]} : 3'h0;
    m[15] = m[15] ^ c[11];
    return {m, e * 6'h06};
  endfunction : decode
  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      num_errors++;
      finish_test();
    end
  endtask : apb
  task automatic wait_valid(input int k);
    for (int n = 0; n < 40 && nv == k; n++) @(posedge sys_clk);
    #1;
    if (nv == k) begin
      num_errors++;
      finish_test();
    end
  endtask : wait_valid
  task automatic count(input int cycles, input int e);
    int c0;
    #1 c0 = nv;
    repeat (cycles) @(posedge sys_clk);
    #1;
    `CHK(nv - c0, e)
  endtask : count
  initial begin
    void'($urandom(32'h57e1b823));
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    apb(1'b0, 8'h00, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, 8'h14, 32'h0);
    `CHK(err, 1'b1)
    `CHK(rd, 32'h0)
    dat = $urandom;
    apb(1'b1, 8'h00, dat);
    apb(1'b0, 8'h00, 32'h0);
    `CHK(rd, {16'h0, dat[15:0]})
    `CHK(fixed_gain_mode, dat[15])
    $display("test registers done");
    apb(1'b1, 8'h04, {12'h0, en_strobe, 14'h0, in_test});
    for (int d = 0; d < 8; d++) begin
      dat = {13'h0, d[2:0], 16'($urandom)};
      apb(1'b1, 8'h00, {22'h0, d[2:0], 7'h0});
      apb(1'b1, 8'h08, dat);
      n0 = nv;
      apb(1'b1, 8'h0c, 32'h0);
      #1 sc = cyc;
      wait_valid(n0);
      // strobe one cycle after the write edge, output flop one more, seen at the next edge
      `CHK(vcyc - sc, 2 + d)
      `CHK({vs, vg}, {dat[15:0], dat[18:16] * 6'h06})
      count(10, 0);
    end
    apb(1'b0, 8'h10, 32'h0);
    `CHK(rd, {10'h0, dat[18:16] * 6'h06, dat[15:0]})
    $display("test delay done");
    apb(1'b1, 8'h04, {12'h0, en_off, 14'h0, in_test});
    count(10, 0);
    apb(1'b1, 8'h00, 32'h00000400);
    repeat (6) @(posedge sys_clk);
    count(10, 10);
    `CHK(vs, 16'h0)
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h04, {12'h0, en_on, 14'h0, in_test});
    repeat (6) @(posedge sys_clk);
    count(10, 10);
    $display("test enable done");
    for (int k = 0; k < 16; k++) begin
      @(posedge sys_clk);
      foreach (w[i]) w[i] <= 17'($urandom);
      cfg = ($urandom & 32'h0000b810) | (32'(k[3:2]) << 2);
      apb(1'b1, 8'h04, {12'h0, en_on, 15'h0, k[1:0]});
      apb(1'b1, 8'h00, cfg);
      // let words captured under the old setting drain through the crossing
      repeat (20) @(posedge sys_clk);
      exp_fmt = decode(cfg, w[k % 4]);
      chk_on = 1'b1;
      repeat (20) @(posedge sys_clk);
      #1;
      chk_on = 1'b0;
      `CHK({vs, vg}, decode(cfg, w[k % 4]))
      `CHK(fixed_gain_mode, cfg[15])
    end
    $display("test formats done");
    finish_test();
  end
endmodule : tb_channel_input_formatter
